// ===== logic/wwd_pkg.sv
// constants, state type and helpers shared by the windowed watchdog files
package wwd_pkg;

  // ****************************************
  // clocks and timing
  // ****************************************
  localparam int unsigned SYS_CLK_HZ = 32'h02FA_F080;  // 50 MHz system clock
  localparam int unsigned WDOG_CLK_HZ = 32'h0000_8000; // watchdog count rate, plain default
  // system cycles per watchdog count step, rounded down
  localparam int unsigned TICK_CYCLES = SYS_CLK_HZ / WDOG_CLK_HZ;
  // watchdog steps a control or clear write takes to cross domains
  localparam logic [1:0] SYNC_TICKS = 2'h2;

  // ****************************************
  // period encoding
  // ****************************************
  localparam logic [15:0] PERIOD_BASE = 16'h0008; // length at code 0x0
  localparam logic [3:0] CODE_MAX = 4'hB;         // last legal code, 16384 steps
  localparam logic [7:0] CLEAR_KEY = 8'hA5;
  localparam logic [15:0] CNT_ONE = 16'h0001;

  // ****************************************
  // power-on defaults before the user row is loaded
  // ****************************************
  localparam logic [3:0] CODE_RST = 4'h0;
  localparam logic [1:0] SYNC_RST = 2'h0;
  localparam logic [15:0] CNT_RST = 16'h0000;

  // whole state of the watchdog core
  typedef struct packed {
    logic load_done;
    logic ctrl_en;
    logic ctrl_win;
    logic ctrl_lock;
    logic [3:0] closed_code;
    logic [3:0] open_code;
    logic [3:0] delay_code;
    logic run_en;
    logic run_win;
    logic run_lock;
    logic [15:0] cnt;
    logic p_v;
    logic p_clr;
    logic p_key;
    logic [1:0] sync_cnt;
    logic q_v;
    logic q_clr;
    logic q_key;
    logic hc_v;
    logic [7:0] hc;
    logic he_v;
    logic [3:0] he;
    logic hw_v;
    logic hw_win;
    logic hw_lock;
    logic irq_en;
    logic irq_flag;
    logic irq;
    logic sys_reset;
  } wwd_state_t;

  // code to count of watchdog steps; reserved codes clamp to the longest
  function automatic logic [15:0] wwd_len(input logic [3:0] code);
    logic [3:0] c;
    c = (code > CODE_MAX) ? CODE_MAX : code;
    return PERIOD_BASE << c;
  endfunction : wwd_len

endpackage : wwd_pkg

// ===== logic/wwd_tick_div.sv
// divider that turns the system clock into the watchdog step enable
`timescale 1ns/1ps

module wwd_tick_div import wwd_pkg::*; #(
  parameter int unsigned DIV = TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  output logic tick
);

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } wwd_div_t;

  wwd_div_t st;
  wwd_div_t next_st;

  // count to the divide value, then emit one enable cycle
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == 16'(DIV - 1)) begin
      next_st.cnt = CNT_RST;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + CNT_ONE;
    end
  end

  // register the divider state
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

endmodule : wwd_tick_div

// ===== logic/wwd_core.sv
// windowed watchdog core: settings, sync tracking, period counter and warning flag
`timescale 1ns/1ps

// Operation
// - enable clear stops timer; window bit alone picks the mode
// - window, lock, config and warning setup writes dropped while enabled or enabling
// - protected writes during disabling are held, applied once disable completes
// - power-on loads enable, lock, window, closed, open and warning codes
// - enable write one starts, zero stops, stop only while lock is clear
// - normal mode: reset when open period ends without a clear
// - clear key restarts the period; any other clear value resets at once
// - twelve selectable period lengths
// - codes give 8 steps doubling to 16384 at 0xB; 0xC-0xF reserved
// - warning irq off by default; set strobe enables, clear strobe disables
// - window mode: clear inside closed period resets; accepted in open period
// - window mode: closed from closed code, open from open code, total their sum
// - window mode warning fires when the open period begins
// - normal mode warning fires after the delay count from period start
// - delay beyond the period: reset first, warning never raised
// - lock keeps timer running; only power-on clears it; zero write ignored
// - under lock config and warning setup frozen; window bit and irq enables writable
// - flag set on warning; irq while flag and enable both set
// - writing one clears the flag, zero does nothing
// - one shared irq line; software reads the flag to identify cause
// - control and clear writes cross into the count domain
// - pending bit set at once, cleared when the crossing completes
// - sync write while pending stalls, then completes
// - enable reads back at once, takes effect when pending clears
module wwd_core import wwd_pkg::*; #(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic nvm_enable,
  input wire logic nvm_lock,
  input wire logic nvm_window,
  input wire logic [3:0] nvm_closed,
  input wire logic [3:0] nvm_open,
  input wire logic [3:0] nvm_delay,
  input wire logic ctrl_wr,
  input wire logic ctrl_wr_enable,
  input wire logic ctrl_wr_window,
  input wire logic ctrl_wr_lock,
  input wire logic cfg_wr,
  input wire logic [3:0] cfg_wr_closed,
  input wire logic [3:0] cfg_wr_open,
  input wire logic ew_setup_wr,
  input wire logic [3:0] ew_setup_wr_delay,
  input wire logic irq_enable_set,
  input wire logic irq_enable_clear,
  input wire logic irq_flag_clear,
  input wire logic clear_wr,
  input wire logic [7:0] clear_wr_data,
  output logic ctrl_enable,
  output logic ctrl_window,
  output logic permanent_run_lock,
  output logic [3:0] closed_code,
  output logic [3:0] open_code,
  output logic [3:0] early_warn_delay,
  output logic irq_enable,
  output logic irq_flag,
  output logic xdomain_pending,
  output logic bus_stall,
  output logic irq,
  output logic sys_reset_req
);

  // ****************************************
  // state and step enable
  // ****************************************
  wwd_state_t st;
  wwd_state_t next_st;
  logic tick;
  logic active;
  logic done;
  logic ew_set;
  logic [15:0] open_len;
  logic [15:0] closed_len;
  logic [15:0] delay_len;
  logic [15:0] nxt;

  // one enable per watchdog step; no second clock domain is needed
  wwd_tick_div #(.DIV(TICK_DIV)) u_div (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .tick(tick)
  );

  // running state comes from the synchronised copies, not the readback
  assign active = st.run_en | st.run_lock;
  assign done = st.p_v && tick && (st.sync_cnt == SYNC_TICKS - 2'h1);
  assign open_len = wwd_len(st.open_code);
  assign closed_len = wwd_len(st.closed_code);
  assign delay_len = wwd_len(st.delay_code);
  assign nxt = st.cnt + CNT_ONE;

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.sys_reset = 1'b0;
    ew_set = 1'b0;
    if (!st.load_done) begin
      // first cycle after release: take the user row settings
      next_st.load_done = 1'b1;
      next_st.ctrl_en = nvm_enable;
      next_st.ctrl_lock = nvm_lock;
      next_st.ctrl_win = nvm_window;
      next_st.closed_code = nvm_closed;
      next_st.open_code = nvm_open;
      next_st.delay_code = nvm_delay;
      next_st.run_en = nvm_enable;
      next_st.run_lock = nvm_lock;
      next_st.run_win = nvm_window;
    end else begin
      // period counter, advanced only on a watchdog step
      if (!active) begin
        next_st.cnt = CNT_RST;
      end else if (tick) begin
        if (st.run_win) begin
          if (nxt == 16'(closed_len + open_len)) begin
            next_st.sys_reset = 1'b1;
            next_st.cnt = CNT_RST;
          end else begin
            next_st.cnt = nxt;
            ew_set = (nxt == closed_len);
          end
        end else begin
          if (nxt == open_len) begin
            // a delay at or past the period never reaches the flag
            next_st.sys_reset = 1'b1;
            next_st.cnt = CNT_RST;
          end else begin
            next_st.cnt = nxt;
            ew_set = (nxt == delay_len);
          end
        end
      end
      // crossing of a control or clear write finishes here
      if (done) begin
        if (st.p_clr) begin
          if (!st.p_key) begin
            next_st.sys_reset = 1'b1;
            next_st.cnt = CNT_RST;
          end else if (active && st.run_win && (st.cnt < closed_len)) begin
            next_st.sys_reset = 1'b1;
            next_st.cnt = CNT_RST;
          end else begin
            next_st.cnt = CNT_RST;
          end
        end else begin
          next_st.run_en = st.ctrl_en;
          next_st.run_win = st.ctrl_win;
          next_st.run_lock = st.ctrl_lock;
        end
        // a stalled write starts its own crossing now
        next_st.p_v = st.q_v;
        next_st.p_clr = st.q_clr;
        next_st.p_key = st.q_key;
        next_st.q_v = 1'b0;
        next_st.sync_cnt = SYNC_RST;
      end else if (st.p_v && tick) begin
        next_st.sync_cnt = st.sync_cnt + 2'h1;
      end
      // accept a new synchronised write, or park it behind the busy one
      if (ctrl_wr || clear_wr) begin
        if (!next_st.p_v) begin
          next_st.p_v = 1'b1;
          next_st.p_clr = clear_wr;
          next_st.p_key = (clear_wr_data == CLEAR_KEY);
          next_st.sync_cnt = SYNC_RST;
        end else begin
          next_st.q_v = 1'b1;
          next_st.q_clr = clear_wr;
          next_st.q_key = (clear_wr_data == CLEAR_KEY);
        end
      end
      // control readback changes at once; protected fields are checked
      if (ctrl_wr) begin
        if (st.ctrl_lock) begin
          next_st.ctrl_en = st.ctrl_en | ctrl_wr_enable;
          next_st.ctrl_win = ctrl_wr_window;
        end else begin
          next_st.ctrl_en = ctrl_wr_enable;
          if (st.ctrl_en || ctrl_wr_enable) begin
            next_st.hw_v = st.hw_v;
          end else if (active) begin
            next_st.hw_v = 1'b1;
            next_st.hw_win = ctrl_wr_window;
            next_st.hw_lock = ctrl_wr_lock;
          end else begin
            next_st.ctrl_win = ctrl_wr_window;
            next_st.ctrl_lock = ctrl_wr_lock;
          end
        end
      end
      // configuration write: frozen under lock, dropped while enabled
      if (cfg_wr && !st.ctrl_lock && !st.ctrl_en) begin
        if (active) begin
          next_st.hc_v = 1'b1;
          next_st.hc = {cfg_wr_closed, cfg_wr_open};
        end else begin
          next_st.closed_code = cfg_wr_closed;
          next_st.open_code = cfg_wr_open;
        end
      end
      if (ew_setup_wr && !st.ctrl_lock && !st.ctrl_en) begin
        if (active) begin
          next_st.he_v = 1'b1;
          next_st.he = ew_setup_wr_delay;
        end else begin
          next_st.delay_code = ew_setup_wr_delay;
        end
      end
      // re-enabling before the disable finished throws the held writes away
      if (next_st.ctrl_en) begin
        next_st.hc_v = 1'b0;
        next_st.he_v = 1'b0;
        next_st.hw_v = 1'b0;
      end else if (!active && !st.p_v) begin
        // disable has completed: held writes land now
        if (st.hc_v) begin
          next_st.closed_code = st.hc[7:4];
          next_st.open_code = st.hc[3:0];
          next_st.hc_v = 1'b0;
        end
        if (st.he_v) begin
          next_st.delay_code = st.he;
          next_st.he_v = 1'b0;
        end
        if (st.hw_v) begin
          next_st.ctrl_win = st.hw_win;
          next_st.ctrl_lock = st.hw_lock;
          next_st.run_win = st.hw_win;
          next_st.run_lock = st.hw_lock;
          next_st.hw_v = 1'b0;
        end
      end
      // irq enable: clear strobe wins if both arrive together
      if (irq_enable_set) begin
        next_st.irq_en = 1'b1;
      end
      if (irq_enable_clear) begin
        next_st.irq_en = 1'b0;
      end
      // flag: a warning in the clearing cycle is kept
      if (irq_flag_clear) begin
        next_st.irq_flag = 1'b0;
      end
      if (ew_set) begin
        next_st.irq_flag = 1'b1;
      end
    end
    next_st.irq = next_st.irq_flag & next_st.irq_en;
  end

  // ****************************************
  // state register
  // ****************************************
  // async reset to constants; user row values are taken one edge later
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ctrl_enable = st.ctrl_en;
  assign ctrl_window = st.ctrl_win;
  assign permanent_run_lock = st.ctrl_lock;
  assign closed_code = st.closed_code;
  assign open_code = st.open_code;
  assign early_warn_delay = st.delay_code;
  assign irq_enable = st.irq_en;
  assign irq_flag = st.irq_flag;
  assign xdomain_pending = st.p_v;
  assign bus_stall = st.q_v;
  assign irq = st.irq;
  assign sys_reset_req = st.sys_reset;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_stopped_quiet: assert property (st.load_done && !active && !st.p_v |=> !st.sys_reset)
    else $error("reset request while stopped");
  a_cfg_discard: assert property (st.load_done && cfg_wr && st.ctrl_en |=> $stable(st.open_code))
    else $error("config changed while enabled");
  a_cfg_held: assert property (st.load_done && cfg_wr && !st.ctrl_en && !st.ctrl_lock && active
    |=> st.hc_v || st.ctrl_en)
    else $error("config write during disable not held");
  a_row_load: assert property (!st.load_done |=> st.ctrl_en == $past(nvm_enable)
    && st.open_code == $past(nvm_open))
    else $error("user row not loaded");
  // a lock taken while enable is low may keep enable low; it only forbids dropping it
  a_lock_sticks: assert property (st.ctrl_lock |=> st.ctrl_lock && (st.ctrl_en || !$past(st.ctrl_en)))
    else $error("lock or enable dropped under lock");
  a_normal_timeout: assert property (st.load_done && active && !st.run_win && tick && nxt == open_len
    |=> st.sys_reset)
    else $error("missed normal timeout");
  a_bad_key: assert property (st.load_done && done && st.p_clr && !st.p_key |=> st.sys_reset)
    else $error("bad clear value did not reset");
  a_flag_kept: assert property (st.load_done && ew_set && irq_flag_clear |=> st.irq_flag)
    else $error("warning lost against clear");
  a_irq_line: assert property (st.irq == (st.irq_flag && st.irq_en))
    else $error("irq does not follow flag and enable");
  a_pending_set: assert property (st.load_done && ctrl_wr |=> st.p_v)
    else $error("pending not set at once");
  a_stall_park: assert property (st.load_done && clear_wr && st.p_v && !done |=> st.q_v)
    else $error("write during pending not parked");
  a_stopped_count: assert property (st.load_done && !active |=> st.cnt == CNT_RST)
    else $error("counter moved while stopped");
  a_enable_apply: assert property (st.load_done && done && !st.p_clr |=> st.run_en == $past(st.ctrl_en))
    else $error("enable not applied at crossing end");
  a_win_timeout: assert property (st.load_done && active && st.run_win && tick
    && nxt == 16'(closed_len + open_len) |=> st.sys_reset)
    else $error("missed window timeout");
  a_ew_normal: assert property (st.load_done && active && !st.run_win && tick
    && nxt == delay_len && nxt != open_len |=> st.irq_flag)
    else $error("normal warning missed");
  a_ew_window: assert property (st.load_done && active && st.run_win && tick && nxt == closed_len
    |=> st.irq_flag)
    else $error("window warning missed");
  a_early_clear: assert property (st.load_done && done && st.p_clr && st.p_key && active
    && st.run_win && st.cnt < closed_len |=> st.sys_reset)
    else $error("early clear did not reset");
  a_key_restart: assert property (st.load_done && done && st.p_clr && st.p_key
    && !(active && st.run_win && st.cnt < closed_len) |=> st.cnt == CNT_RST)
    else $error("keyed clear did not restart");
  a_irq_off: assert property (st.load_done && irq_enable_clear |=> !st.irq_en)
    else $error("irq enable not cleared");
  a_irq_on: assert property (st.load_done && irq_enable_set && !irq_enable_clear |=> st.irq_en)
    else $error("irq enable not set");
  a_flag_clear: assert property (st.load_done && irq_flag_clear && !ew_set |=> !st.irq_flag)
    else $error("flag not cleared");
  a_lock_frozen: assert property (st.load_done && st.ctrl_lock && !st.hc_v && !st.he_v
    && (cfg_wr || ew_setup_wr) |=> $stable(st.closed_code) && $stable(st.open_code) && $stable(st.delay_code))
    else $error("setup changed under lock");
  a_pending_clear: assert property (st.load_done && done && !st.q_v && !ctrl_wr && !clear_wr
    |=> !st.p_v)
    else $error("pending not cleared at crossing end");

endmodule : wwd_core

// ===== testbench/wwd_core_bench.sv
// self-checking bench for the windowed watchdog core, driven from its ports
`timescale 1ns/1ps

module wwd_core_bench;
  import wwd_pkg::*;

  // ****************************************
  // clock, reset and port signals
  // ****************************************
  localparam int DIV = 4; // short step so whole periods fit in a quick run
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic nvm_enable = 1'b0, nvm_lock = 1'b0, nvm_window = 1'b0;
  logic [3:0] nvm_closed = 4'h0, nvm_open = 4'h0, nvm_delay = 4'h0;
  logic ctrl_wr = 1'b0, ctrl_wr_enable = 1'b0, ctrl_wr_window = 1'b0, ctrl_wr_lock = 1'b0;
  logic cfg_wr = 1'b0, ew_setup_wr = 1'b0;
  logic [3:0] cfg_wr_closed = 4'h0, cfg_wr_open = 4'h0, ew_setup_wr_delay = 4'h0;
  logic irq_enable_set = 1'b0, irq_enable_clear = 1'b0, irq_flag_clear = 1'b0;
  logic clear_wr = 1'b0;
  logic [7:0] clear_wr_data = 8'h00;
  logic ctrl_enable, ctrl_window, permanent_run_lock, irq_enable, irq_flag;
  logic xdomain_pending, bus_stall, irq, sys_reset_req;
  logic [3:0] closed_code, open_code, early_warn_delay;
  int miscompares = 0;
  int checked = 0;

  always #10 sys_clk = ~sys_clk;

  wwd_core #(.TICK_DIV(DIV)) wwd_core_inst (
    .sys_clk(sys_clk), .rstn(rstn),
    .nvm_enable(nvm_enable), .nvm_lock(nvm_lock), .nvm_window(nvm_window),
    .nvm_closed(nvm_closed), .nvm_open(nvm_open), .nvm_delay(nvm_delay),
    .ctrl_wr(ctrl_wr), .ctrl_wr_enable(ctrl_wr_enable), .ctrl_wr_window(ctrl_wr_window),
    .ctrl_wr_lock(ctrl_wr_lock), .cfg_wr(cfg_wr), .cfg_wr_closed(cfg_wr_closed),
    .cfg_wr_open(cfg_wr_open), .ew_setup_wr(ew_setup_wr), .ew_setup_wr_delay(ew_setup_wr_delay),
    .irq_enable_set(irq_enable_set), .irq_enable_clear(irq_enable_clear),
    .irq_flag_clear(irq_flag_clear), .clear_wr(clear_wr), .clear_wr_data(clear_wr_data),
    .ctrl_enable(ctrl_enable), .ctrl_window(ctrl_window), .permanent_run_lock(permanent_run_lock),
    .closed_code(closed_code), .open_code(open_code), .early_warn_delay(early_warn_delay),
    .irq_enable(irq_enable), .irq_flag(irq_flag), .xdomain_pending(xdomain_pending),
    .bus_stall(bus_stall), .irq(irq), .sys_reset_req(sys_reset_req)
  );

  // ****************************************
  // shared helpers
  // ****************************************
  task automatic give_verdict();
    if (miscompares == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("ERROR at %0t: %s", $time, msg);
    end
  endtask : chk

  // drives one strobe line only, so back-to-back strobes never touch a signal twice
  task automatic drive_strobe(input int kind, input logic v);
    case (kind)
      0: ctrl_wr = v;
      1: cfg_wr = v;
      2: ew_setup_wr = v;
      3: irq_enable_set = v;
      4: irq_enable_clear = v;
      5: irq_flag_clear = v;
      default: clear_wr = v;
    endcase
  endtask : drive_strobe

  // one-cycle strobe launched at a falling edge; data is set up by the caller
  task automatic strobe(input int kind);
    drive_strobe(kind, 1'b1);
    @(negedge sys_clk);
    drive_strobe(kind, 1'b0);
  endtask : strobe

  // counts cycles until an event; returns max+1 when it never came
  task automatic wait_sig(input int which, input int max, output int n);
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < max) begin
      @(negedge sys_clk);
      n++;
      case (which)
        0: hit = (sys_reset_req === 1'b1);
        1: hit = (irq_flag === 1'b1);
        default: hit = (xdomain_pending === 1'b0);
      endcase
    end
    if (!hit) n = max + 1;
  endtask : wait_sig

  // power-on with a given user row; returns at the first edge that may take a request
  task automatic do_reset(input logic en, lk, wn, input logic [3:0] cl, op, dl);
    rstn = 1'b0;
    {nvm_enable, nvm_lock, nvm_window} = {en, lk, wn};
    {nvm_closed, nvm_open, nvm_delay} = {cl, op, dl};
    repeat (10) @(negedge sys_clk);
    rstn = 1'b1;
    @(negedge sys_clk);
    chk(ctrl_enable === en && permanent_run_lock === lk && ctrl_window === wn, "row bits");
    chk(closed_code === cl && open_code === op && early_warn_delay === dl, "row codes");
    chk(irq_enable === 1'b0 && irq_flag === 1'b0 && irq === 1'b0, "irq defaults");
  endtask : do_reset

  // ****************************************
  // scenarios
  // ****************************************
  // enable and disable by write, with protected writes refused and held
  task automatic t_enable();
    int n;
    do_reset(1'b0, 1'b0, 1'b0, 4'h0, 4'h0, 4'h0);
    wait_sig(0, 80, n);
    chk(n == 81, "stopped timer reset");
    {cfg_wr_closed, cfg_wr_open} = {4'h3, 4'h2};
    strobe(1);
    chk(closed_code === 4'h3 && open_code === 4'h2, "config write while off");
    {ctrl_wr_enable, ctrl_wr_window, ctrl_wr_lock} = 3'b110;
    strobe(0);
    chk(ctrl_enable === 1'b1 && xdomain_pending === 1'b1, "enable readback");
    chk(ctrl_window === 1'b0, "window with enable");
    {cfg_wr_closed, cfg_wr_open, ew_setup_wr_delay} = {4'h5, 4'h5, 4'h4};
    strobe(1);
    strobe(2);
    chk(closed_code === 4'h3 && open_code === 4'h2 && early_warn_delay === 4'h0, "enabled write");
    wait_sig(2, 12, n);
    chk(n <= 8, "enable crossing");
    ctrl_wr_enable = 1'b0;
    ctrl_wr_window = 1'b0;
    strobe(0);
    {cfg_wr_closed, cfg_wr_open} = {4'h1, 4'h0};
    strobe(1);
    chk(closed_code === 4'h3 && xdomain_pending === 1'b1, "held during disable");
    wait_sig(2, 12, n);
    repeat (2) @(negedge sys_clk);
    chk(closed_code === 4'h1 && open_code === 4'h0, "held write applied");
    wait_sig(0, 150, n);
    chk(n == 151, "disabled timer reset");
  endtask : t_enable

  // normal mode warning, irq enables and flag clear, then time-out
  task automatic t_normal();
    int n1;
    int n2;
    do_reset(1'b1, 1'b0, 1'b0, 4'h0, 4'h1, 4'h0);
    strobe(3);
    wait_sig(1, 60, n1);
    chk(n1 >= 8 * DIV - 8 && n1 <= 8 * DIV + 4, "warning offset");
    chk(irq === 1'b1, "irq on flag");
    strobe(4);
    chk(irq === 1'b0 && irq_flag === 1'b1, "enable clear");
    strobe(3);
    chk(irq === 1'b1, "enable set again");
    strobe(5);
    chk(irq_flag === 1'b0 && irq === 1'b0, "flag clear");
    wait_sig(0, 80, n2);
    n2 = n2 + n1 + 4;
    chk(n2 >= 16 * DIV - 8 && n2 <= 16 * DIV + 6, "time-out length");
  endtask : t_normal

  // warning delay beyond the period never raises the flag
  task automatic t_late_warn();
    int n;
    do_reset(1'b1, 1'b0, 1'b0, 4'h0, 4'h0, 4'h1);
    strobe(3);
    wait_sig(0, 60, n);
    chk(n >= 8 * DIV - 8 && n <= 8 * DIV + 4, "short time-out");
    chk(irq_flag === 1'b0, "late warning");
  endtask : t_late_warn

  // key clears keep it alive; any other value resets at once
  task automatic t_clear();
    int n;
    do_reset(1'b1, 1'b0, 1'b0, 4'h0, 4'h1, 4'h0);
    clear_wr_data = CLEAR_KEY;
    repeat (4) begin
      strobe(6);
      wait_sig(0, 40, n);
      chk(n == 41, "keyed clear");
    end
    clear_wr_data = 8'h12;
    strobe(6);
    wait_sig(0, 16, n);
    chk(n <= 2 * DIV + 4, "bad clear value");
  endtask : t_clear

  // window mode: early clear resets, warning at open, total is the sum
  task automatic t_window();
    int n;
    do_reset(1'b1, 1'b0, 1'b1, 4'h0, 4'h1, 4'h3);
    repeat (3) @(negedge sys_clk);
    clear_wr_data = CLEAR_KEY;
    strobe(6);
    wait_sig(0, 16, n);
    chk(n <= 2 * DIV + 4, "clear in closed window");
    do_reset(1'b1, 1'b0, 1'b1, 4'h0, 4'h1, 4'h3);
    strobe(3);
    wait_sig(1, 60, n);
    chk(n >= 8 * DIV - 8 && n <= 8 * DIV + 4, "warning at open");
    strobe(6);
    wait_sig(0, 140, n);
    chk(n >= 24 * DIV && n <= 26 * DIV + 8, "window total");
  endtask : t_window

  // permanent lock: enable and lock zero ignored, config frozen, window and irq writable
  task automatic t_lock();
    int n;
    do_reset(1'b1, 1'b1, 1'b0, 4'h0, 4'h2, 4'h0); // enable and lock both set from the user row, window off
    {ctrl_wr_enable, ctrl_wr_window, ctrl_wr_lock} = 3'b010;
    strobe(0);
    chk(ctrl_enable === 1'b1 && permanent_run_lock === 1'b1, "lock holds");
    chk(ctrl_window === 1'b1, "window under lock");
    wait_sig(2, 12, n);
    {cfg_wr_closed, cfg_wr_open, ew_setup_wr_delay} = {4'h4, 4'h4, 4'h4};
    strobe(1);
    strobe(2);
    chk(open_code === 4'h2 && closed_code === 4'h0 && early_warn_delay === 4'h0, "frozen");
    strobe(3);
    chk(irq_enable === 1'b1, "irq enable under lock");
    wait_sig(0, 300, n);
    chk(n <= 300, "runs while locked");
  endtask : t_lock

  // a second sync write while one is in flight is parked, then completes
  task automatic t_stall();
    int n;
    do_reset(1'b0, 1'b0, 1'b0, 4'h0, 4'h2, 4'h0);
    {ctrl_wr_enable, ctrl_wr_window, ctrl_wr_lock} = 3'b100;
    clear_wr_data = CLEAR_KEY;
    strobe(0);
    strobe(6);
    chk(bus_stall === 1'b1 && xdomain_pending === 1'b1, "parked write");
    wait_sig(2, 30, n);
    chk(n <= 30 && bus_stall === 1'b0, "parked write done");
  endtask : t_stall

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    t_enable();
    t_normal();
    t_late_warn();
    t_clear();
    t_window();
    t_lock();
    t_stall();
    give_verdict();
  end

  // whole run needs about 1000 cycles; this limit leaves ample margin
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    $display("ERROR at %0t: run timed out", $time);
    give_verdict();
  end

endmodule : wwd_core_bench
